// [verilog/pttd_delay_counter.sv]
// Post-trigger delay counter with controller port loads and status
`timescale 1ns/1ns
module pttd_delay_counter
    import pttd_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_port_addr,
    input wire logic [7:0] i_controller_bus_lines,
    input wire logic i_port_wr,
    input wire logic i_port_rd,
    input wire logic i_trigger_satisfied,
    input wire logic i_step_clock,
    output logic [7:0] o_read_data,
    output logic o_stop_acq,
    output logic o_lower_section_load_enable
);
    import pttd_pkg::*;

    logic [PTTD_CNT_W-1:0] count_reg;
    logic [PTTD_CNT_W-1:0] count_next;
    logic triggered_reg;
    logic step_pulse;
    logic wr_low;
    logic wr_mid;
    logic wr_top;
    logic wr_ctrl;
    logic any_load;
    logic at_terminal;
    logic advance;
    logic [3:0] lower_load_data_lines;
    logic [7:0] upper_load_data_lines;
    logic [3:0] stop_age_reg;

    // Step input comes from another clock source
    pttd_step_sync u_step_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async(i_step_clock),
        .o_rise(step_pulse)
    );

    // Port decode and load strobes
    assign lower_load_data_lines =
        i_controller_bus_lines[PTTD_LOW_DATA_MSB:PTTD_LOW_DATA_LSB];
    assign upper_load_data_lines = i_controller_bus_lines;
    assign wr_ctrl = i_port_wr && i_port_addr == PTTD_MEM_CTRL_PORT;
    assign wr_low = i_port_wr && i_port_addr == PTTD_LOW_LOAD_PORT
        && o_lower_section_load_enable;
    assign wr_mid = i_port_wr && i_port_addr == PTTD_MID_LOAD_PORT;
    assign wr_top = i_port_wr && i_port_addr == PTTD_TOP_LOAD_PORT;
    assign any_load = wr_low || wr_mid || wr_top;
    assign at_terminal = &count_reg;

    // Step advances only while enable set; trigger gate otherwise
    assign advance = !at_terminal && (triggered_reg
        || (step_pulse && o_lower_section_load_enable));

    // Memory control: only the lower-section enable lives here
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_lower_section_load_enable <= 1'b0;
        end else if (wr_ctrl) begin
            o_lower_section_load_enable <=
                i_controller_bus_lines[PTTD_LOW_EN_BIT];
        end
    end

    // Trigger latch; a new load rearms, a trigger in that cycle wins
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            triggered_reg <= 1'b0;
        end else if (i_trigger_satisfied) begin
            triggered_reg <= 1'b1;
        end else if (any_load) begin
            triggered_reg <= 1'b0;
        end
    end

    // Loads take priority over counting; sections load independently
    always_comb begin
        count_next = count_reg;
        if (any_load) begin
            if (wr_low) begin
                count_next[PTTD_LOW_MSB:PTTD_LOW_LSB] =
                    lower_load_data_lines;
            end
            if (wr_mid) begin
                count_next[PTTD_MID_MSB:PTTD_MID_LSB] =
                    upper_load_data_lines[PTTD_MID_DATA_MSB:
                    PTTD_MID_DATA_LSB];
            end
            if (wr_top) begin
                count_next[PTTD_TOP_MSB:PTTD_TOP_LSB] =
                    upper_load_data_lines[PTTD_TOP_DATA_MSB:
                    PTTD_TOP_DATA_LSB];
            end
        end else if (advance) begin
            count_next = count_reg + PTTD_CNT_ONE;
        end
    end

    // Terminal count is sticky because advance stops at all ones
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_reg <= PTTD_CNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // Stop flag from next value so it lines up with the count
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_stop_acq <= 1'b0;
        end else begin
            o_stop_acq <= &count_next;
        end
    end

    pttd_status_port u_status (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_port_rd(i_port_rd),
        .i_port_addr(i_port_addr),
        .i_count(count_reg),
        .o_read_data(o_read_data)
    );

    // Age of a standing stop flag, only for the hold check below;
    // saturates so a long hold cannot wrap it back to zero
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            stop_age_reg <= 4'h0;
        end else if (!o_stop_acq || any_load) begin
            stop_age_reg <= 4'h0;
        end else if (!(&stop_age_reg)) begin
            stop_age_reg <= stop_age_reg + 4'h1;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    sequence s_quiet;
        !any_load && !wr_ctrl;
    endsequence

    sequence s_last_step;
        triggered_reg && count_reg == (PTTD_CNT_ONES - PTTD_CNT_ONE)
            && !any_load;
    endsequence

    sequence s_idle_pre_trig;
        !triggered_reg && !step_pulse && !any_load;
    endsequence

    sequence s_ctrl_write;
        i_port_wr && i_port_addr == PTTD_MEM_CTRL_PORT;
    endsequence

    sequence s_mid_write;
        i_port_wr && i_port_addr == PTTD_MID_LOAD_PORT;
    endsequence

    sequence s_top_write;
        i_port_wr && i_port_addr == PTTD_TOP_LOAD_PORT;
    endsequence

    sequence s_status_read;
        i_port_rd && i_port_addr == PTTD_STATUS_PORT;
    endsequence

    sequence s_armed;
        i_trigger_satisfied && !any_load ##1 !any_load && !at_terminal;
    endsequence

    chk_stop_terminal: assert property (
        o_stop_acq == (count_reg == PTTD_CNT_ONES))
    else $error("stop flag disagrees with terminal count");

    chk_last_step_stop: assert property (
        s_last_step |=> o_stop_acq && count_reg == PTTD_CNT_ONES)
    else $error("last advance did not raise stop");

    chk_count_advance: assert property (
        triggered_reg && !at_terminal && !any_load
        |=> count_reg == $past(count_reg) + PTTD_CNT_ONE)
    else $error("counter did not advance by one");

    chk_hold_pre_trig: assert property (
        s_idle_pre_trig |=> $stable(count_reg))
    else $error("counter moved before trigger");

    chk_stop_sticky: assert property (
        o_stop_acq ##0 s_quiet[*2] |=> o_stop_acq)
    else $error("stop flag dropped without load");

    chk_low_load: assert property (
        i_port_wr && i_port_addr == PTTD_LOW_LOAD_PORT
        && o_lower_section_load_enable
        |=> count_reg[PTTD_LOW_MSB:PTTD_LOW_LSB]
            == $past(i_controller_bus_lines[3:0]))
    else $error("lower section not loaded");

    chk_low_refuse: assert property (
        i_port_wr && i_port_addr == PTTD_LOW_LOAD_PORT
        && !o_lower_section_load_enable && !triggered_reg
        |=> $stable(count_reg))
    else $error("lower section loaded without enable");

    chk_mid_load: assert property (
        i_port_wr && i_port_addr == PTTD_MID_LOAD_PORT
        |=> count_reg[PTTD_MID_MSB:PTTD_MID_LSB]
            == $past(i_controller_bus_lines[6:0]))
    else $error("mid section not loaded");

    chk_top_load: assert property (
        i_port_wr && i_port_addr == PTTD_TOP_LOAD_PORT
        |=> count_reg[PTTD_TOP_MSB:PTTD_TOP_LSB]
            == $past(i_controller_bus_lines[7:4]))
    else $error("top section not loaded");

    chk_status_read: assert property (
        i_port_rd && i_port_addr == PTTD_STATUS_PORT
        |=> o_read_data == {1'b0, ~&$past(count_reg[14:4]),
            5'h00, &$past(count_reg)})
    else $error("status byte wrong");

    chk_step_clock: assert property (
        step_pulse && o_lower_section_load_enable && !triggered_reg
        && !at_terminal && !any_load
        |=> count_reg == $past(count_reg) + PTTD_CNT_ONE)
    else $error("single step did not clock counter");

    chk_enable_write: assert property (
        s_ctrl_write |=> o_lower_section_load_enable
            == $past(i_controller_bus_lines[PTTD_LOW_EN_BIT]))
    else $error("lower load enable not taken from its bit");

    chk_enable_hold: assert property (
        !wr_ctrl |=> $stable(o_lower_section_load_enable))
    else $error("lower load enable moved without a write");

    chk_refuse_keeps_trig: assert property (
        i_port_wr && i_port_addr == PTTD_LOW_LOAD_PORT
        && !o_lower_section_load_enable && triggered_reg
        |=> triggered_reg)
    else $error("refused lower write rearmed the counter");

    chk_trig_latch: assert property (
        i_trigger_satisfied |=> triggered_reg)
    else $error("trigger not latched");

    chk_trig_rearm: assert property (
        !i_trigger_satisfied && any_load |=> !triggered_reg)
    else $error("section load did not rearm the trigger latch");

    chk_first_advance: assert property (
        s_armed |=> count_reg == $past(count_reg) + PTTD_CNT_ONE)
    else $error("first advance after trigger missing");

    chk_no_wrap: assert property (
        at_terminal && !any_load |=> count_reg == PTTD_CNT_ONES)
    else $error("counter left terminal count without a load");

    chk_stop_age: assert property (
        stop_age_reg != 4'h0 |-> o_stop_acq && at_terminal)
    else $error("stop flag did not stand until a load");

    chk_step_gated: assert property (
        step_pulse && !o_lower_section_load_enable && !triggered_reg
        && !any_load |=> $stable(count_reg))
    else $error("single step clocked counter without enable");

    chk_step_single: assert property (
        step_pulse |=> !step_pulse)
    else $error("single step pulse longer than one cycle");

    chk_low_carry: assert property (
        triggered_reg && !any_load && !at_terminal
        && count_reg[PTTD_LOW_MSB:PTTD_LOW_LSB] == 4'hf
        |=> count_reg[PTTD_LOW_MSB:PTTD_LOW_LSB] == 4'h0)
    else $error("lower section did not carry into upper");

    chk_low_keeps_upper: assert property (
        wr_low |=> count_reg[PTTD_TOP_MSB:PTTD_MID_LSB]
            == $past(count_reg[PTTD_TOP_MSB:PTTD_MID_LSB]))
    else $error("lower load disturbed upper section");

    chk_mid_keeps_rest: assert property (
        s_mid_write |=> count_reg[PTTD_LOW_MSB:PTTD_LOW_LSB]
            == $past(count_reg[PTTD_LOW_MSB:PTTD_LOW_LSB])
        && count_reg[PTTD_TOP_MSB:PTTD_TOP_LSB]
            == $past(count_reg[PTTD_TOP_MSB:PTTD_TOP_LSB]))
    else $error("mid load disturbed other sections");

    chk_top_keeps_rest: assert property (
        s_top_write |=> count_reg[PTTD_MID_MSB:PTTD_LOW_LSB]
            == $past(count_reg[PTTD_MID_MSB:PTTD_LOW_LSB]))
    else $error("top load disturbed lower bits");

    chk_read_idle: assert property (
        !(i_port_rd && i_port_addr == PTTD_STATUS_PORT)
        |=> o_read_data == PTTD_BYTE_ZERO)
    else $error("read data not zero outside a status read");

    chk_read_other: assert property (
        i_port_rd && i_port_addr != PTTD_STATUS_PORT
        |=> o_read_data == PTTD_BYTE_ZERO)
    else $error("another read port returned data");

    chk_read_spare: assert property (
        o_read_data[7] == 1'b0 && o_read_data[5:1] == 5'h00)
    else $error("unused status bits not zero");

    chk_lower_zero_read: assert property (
        s_status_read ##0 !(&count_reg[PTTD_LOW_MSB:PTTD_LOW_LSB])
        && (&count_reg[PTTD_TOP_MSB:PTTD_MID_LSB])
        |=> o_read_data == PTTD_BYTE_ZERO)
    else $error("lower zero did not clear the status byte");

    chk_upper_zero_read: assert property (
        s_status_read ##0 !(&count_reg[PTTD_TOP_MSB:PTTD_MID_LSB])
        |=> o_read_data[PTTD_UPDONE_BIT] && !o_read_data[PTTD_STOP_BIT])
    else $error("upper zero did not show as upper-done");

    chk_terminal_read: assert property (
        s_status_read ##0 at_terminal
        |=> o_read_data[PTTD_STOP_BIT] && !o_read_data[PTTD_UPDONE_BIT])
    else $error("terminal count did not read as stop");
endmodule : pttd_delay_counter

// [verilog/pttd_pkg.sv]
// Shared constants for the post-trigger delay counter
package pttd_pkg;
    // Controller port map (8-bit port addresses)
    localparam logic [7:0] PTTD_STATUS_PORT = 8'h02;
    localparam logic [7:0] PTTD_TOP_LOAD_PORT = 8'h03;
    localparam logic [7:0] PTTD_LOW_LOAD_PORT = 8'h05;
    localparam logic [7:0] PTTD_MID_LOAD_PORT = 8'h06;
    localparam logic [7:0] PTTD_MEM_CTRL_PORT = 8'h0c;

    // Counter geometry: low 4, mid 7, top 4 bits
    localparam int PTTD_CNT_W = 15;
    localparam int PTTD_LOW_LSB = 0;
    localparam int PTTD_LOW_MSB = 3;
    localparam int PTTD_MID_LSB = 4;
    localparam int PTTD_MID_MSB = 10;
    localparam int PTTD_TOP_LSB = 11;
    localparam int PTTD_TOP_MSB = 14;
    localparam int PTTD_UP_W = 11;

    // Data bus lanes feeding each section
    localparam int PTTD_LOW_DATA_LSB = 0;
    localparam int PTTD_LOW_DATA_MSB = 3;
    localparam int PTTD_MID_DATA_LSB = 0;
    localparam int PTTD_MID_DATA_MSB = 6;
    localparam int PTTD_TOP_DATA_LSB = 4;
    localparam int PTTD_TOP_DATA_MSB = 7;

    // Field positions
    localparam int PTTD_LOW_EN_BIT = 5;
    localparam int PTTD_STOP_BIT = 0;
    localparam int PTTD_UPDONE_BIT = 6;

    // Reset values and terminal count
    localparam logic [14:0] PTTD_CNT_RESET = 15'h0000;
    localparam logic [14:0] PTTD_CNT_ONES = 15'h7fff;
    localparam logic [14:0] PTTD_CNT_ONE = 15'h0001;
    localparam logic [7:0] PTTD_BYTE_ZERO = 8'h00;
endpackage : pttd_pkg

// [verilog/pttd_step_sync.sv]
// Two-stage synchroniser with rising-edge pulse for the single-step clock
`timescale 1ns/1ns
module pttd_step_sync (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // First stage feeds only the second stage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            last_reg <= 1'b0;
            o_rise <= 1'b0;
        end else begin
            last_reg <= sync_reg;
            o_rise <= sync_reg & ~last_reg;
        end
    end
endmodule : pttd_step_sync

// [verilog/pttd_status_port.sv]
// Registered status read port: stop flag and upper-done only
`timescale 1ns/1ns
module pttd_status_port
    import pttd_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_port_rd,
    input wire logic [7:0] i_port_addr,
    input wire logic [pttd_pkg::PTTD_CNT_W-1:0] i_count,
    output logic [7:0] o_read_data
);
    import pttd_pkg::*;

    logic [7:0] status_next;

    // Counter value itself never reaches the bus
    always_comb begin
        status_next = PTTD_BYTE_ZERO;
        status_next[PTTD_STOP_BIT] = &i_count;
        status_next[PTTD_UPDONE_BIT] =
            ~&i_count[PTTD_TOP_MSB:PTTD_MID_LSB];
    end

    // Unread cycles and other ports return zero
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_read_data <= PTTD_BYTE_ZERO;
        end else if (i_port_rd && i_port_addr == PTTD_STATUS_PORT) begin
            o_read_data <= status_next;
        end else begin
            o_read_data <= PTTD_BYTE_ZERO;
        end
    end
endmodule : pttd_status_port

// [dv/pttd_ctrl_model.sv]
// Controller model: port bus writes, reads and delay programming
`timescale 1ns/1ns
module pttd_ctrl_model (
    input wire logic i_clock,
    input wire logic [7:0] i_read_data,
    output logic [7:0] o_port_addr,
    output logic [7:0] o_bus,
    output logic o_port_wr,
    output logic o_port_rd
);
    initial begin
        o_port_addr = 8'h00;
        o_bus = 8'h00;
        o_port_wr = 1'b0;
        o_port_rd = 1'b0;
    end
    // Bus inverted once released so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_port_addr = a;
        o_bus = d;
        o_port_wr = 1'b1;
        @(posedge i_clock);
        #1;
        o_port_wr = 1'b0;
        o_bus = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_port_addr = a;
        o_port_rd = 1'b1;
        @(posedge i_clock);
        #1;
        o_port_rd = 1'b0;
        d = i_read_data;
    endtask : rd
    // Delay n programmed as its complement
    task automatic load(input logic [14:0] n);
        logic [14:0] v;
        v = ~n;
        wr(8'h0c, 8'h20);
        wr(8'h05, {4'h0, v[3:0]});
        wr(8'h06, {1'b0, v[10:4]});
        wr(8'h03, {v[14:11], 4'h0});
    endtask : load
endmodule : pttd_ctrl_model

// [dv/pttd_delay_counter_test.sv]
// Self-checking bench for the post-trigger delay counter
`timescale 1ns/1ns
module pttd_delay_counter_test;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_trigger_satisfied = 1'b0;
    logic i_step_clock = 1'b0;
    logic [7:0] addr, bus, rdata, got;
    logic wr_s, rd_s, stop, en;
    int err_count = 0;
    int n_compared = 0;
    always #50 i_clock = ~i_clock;
    pttd_delay_counter u_pttd_delay_counter (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_port_addr(addr),
        .i_controller_bus_lines(bus),
        .i_port_wr(wr_s),
        .i_port_rd(rd_s),
        .i_trigger_satisfied(i_trigger_satisfied),
        .i_step_clock(i_step_clock),
        .o_read_data(rdata),
        .o_stop_acq(stop),
        .o_lower_section_load_enable(en)
    );
    pttd_ctrl_model u_pttd_ctrl_model (
        .i_clock(i_clock),
        .i_read_data(rdata),
        .o_port_addr(addr),
        .o_bus(bus),
        .o_port_wr(wr_s),
        .o_port_rd(rd_s)
    );
    task automatic check(input logic [15:0] exp, input logic [15:0] act);
        n_compared++;
        if (act !== exp) begin
            err_count++;
            $display("mismatch at %0t: expected %h, got %h", $time, exp, act);
        end
    endtask : check
    task automatic status(input logic [7:0] exp);
        u_pttd_ctrl_model.rd(8'h02, got);
        check({8'h00, exp}, {8'h00, got});
    endtask : status
    task automatic t_ones;
        u_pttd_ctrl_model.wr(8'h0c, 8'h20);
        check(16'h0001, {15'h0000, en});
        u_pttd_ctrl_model.wr(8'h05, 8'h0f);
        u_pttd_ctrl_model.wr(8'h06, 8'hff);
        u_pttd_ctrl_model.wr(8'h03, 8'hf0);
        check(16'h0001, {15'h0000, stop});
        status(8'h01);
        u_pttd_ctrl_model.rd(8'h05, got);
        check(16'h0000, {8'h00, got});
        $display("test ones done");
    endtask : t_ones
    task automatic t_walk;
        for (int i = 0; i < 4; i++) begin
            u_pttd_ctrl_model.wr(8'h05, 8'h0f ^ (8'h01 << i));
            status(8'h00);
        end
        u_pttd_ctrl_model.wr(8'h05, 8'h0f);
        for (int i = 0; i < 7; i++) begin
            u_pttd_ctrl_model.wr(8'h06, 8'h7f ^ (8'h01 << i));
            status(8'h40);
        end
        u_pttd_ctrl_model.wr(8'h06, 8'hff);
        for (int i = 4; i < 8; i++) begin
            u_pttd_ctrl_model.wr(8'h03, 8'hf0 ^ (8'h01 << i));
            status(8'h40);
        end
        u_pttd_ctrl_model.wr(8'h03, 8'hf0);
        u_pttd_ctrl_model.wr(8'h0c, 8'h00);
        u_pttd_ctrl_model.wr(8'h05, 8'h00);
        status(8'h01);
        $display("test walk done");
    endtask : t_walk
    task automatic t_delay(input logic [14:0] n);
        int k;
        u_pttd_ctrl_model.load(n);
        repeat (5) @(posedge i_clock);
        #1;
        check(16'h0000, {15'h0000, stop});
        i_trigger_satisfied = 1'b1;
        @(posedge i_clock);
        #1;
        i_trigger_satisfied = 1'b0;
        k = 0;
        while (stop !== 1'b1 && k < 40000) begin
            @(posedge i_clock);
            #1;
            k++;
        end
        check({1'b0, n}, k[15:0]);
        repeat (20) @(posedge i_clock);
        #1;
        check(16'h0001, {15'h0000, stop});
        $display("test delay done");
    endtask : t_delay
    // Step held two edges so the synchroniser cannot miss it
    task automatic step_pulse;
        i_step_clock = 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        i_step_clock = 1'b0;
        repeat (8) @(posedge i_clock);
        #1;
    endtask : step_pulse
    task automatic t_step;
        u_pttd_ctrl_model.load(15'h0001);
        u_pttd_ctrl_model.wr(8'h0c, 8'h00);
        step_pulse();
        check(16'h0000, {15'h0000, stop});
        u_pttd_ctrl_model.wr(8'h0c, 8'h20);
        step_pulse();
        check(16'h0001, {15'h0000, stop});
        $display("test step done");
    endtask : t_step
    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (6) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        t_ones();
        t_walk();
        t_delay(15'h0005);
        t_delay(15'h7fff);
        t_step();
        conclude();
    end
    // Longest scenario runs about 33k cycles
    initial begin
        #(100 * 60000);
        err_count++;
        conclude();
    end
endmodule : pttd_delay_counter_test
